// ---- src/uifc_pkg.sv ----
// constants shared by the uart interrupt and fifo control block
package uifc_pkg;
   // register port addresses
   localparam logic [2:0] ADDR_RHOLD  = 3'h0;
   localparam logic [2:0] ADDR_IEMASK = 3'h1;
   localparam logic [2:0] ADDR_ISTAT  = 3'h2;   // read status, write fifo setup
   localparam logic [2:0] ADDR_LSTAT  = 3'h5;
   localparam logic [7:0] IEMASK_RST  = 8'h00;
   localparam logic [7:0] IE_LOW_MASK = 8'h0F;  // bits writable without enhanced mode
   // enable mask fields
   localparam int IE_RECEIVE_READY_PIN_N = 0;
   localparam int IE_TRANSMIT_READY_PIN_N = 1;
   localparam int IE_LSTAT = 2;
   localparam int IE_MODEM = 3;
   localparam int IE_XOFF  = 5;
   localparam int IE_RTS   = 6;
   localparam int IE_CTS   = 7;
   // fifo setup fields
   localparam int FC_EN    = 0;
   localparam int FC_RXRST = 1;
   localparam int FC_TXRST = 2;
   localparam int FC_DMA   = 3;
   localparam int FC_TXTRG = 4;
   localparam int FC_RXTRG = 6;
   // receive word: data in 7:0, parity/framing/break in 10:8
   localparam int RXW      = 11;
   localparam int RX_DEPTH = 32;
   localparam int CNT_W    = 6;
   localparam int ERR_LSB  = 8;
   // status codes, priority 1 first
   localparam logic [5:0] ISC_LSTAT = 6'h06;
   localparam logic [5:0] ISC_RXTO  = 6'h0C;
   localparam logic [5:0] ISC_RECEIVE_READY_PIN_N = 6'h04;
   localparam logic [5:0] ISC_TRANSMIT_READY_PIN_N = 6'h02;
   localparam logic [5:0] ISC_MODEM = 6'h00;
   localparam logic [5:0] ISC_GPIO  = 6'h30;
   localparam logic [5:0] ISC_XOFF  = 6'h10;
   localparam logic [5:0] ISC_FLOW  = 6'h20;
   localparam logic [5:0] ISC_NONE  = 6'h01;
   localparam logic [3:0] SRC_NONE  = 4'h8;
   // trigger levels
   localparam logic [6:0] LVL_DEFAULT = 7'h01;
   localparam logic [6:0] TX_LVL [4] = '{7'h08, 7'h10, 7'h20, 7'h38};
   localparam logic [6:0] RX_LVL [4] = '{7'h08, 7'h10, 7'h38, 7'h3C};
   // receive timeout: four characters plus twelve bit times
   localparam logic [7:0] TO_CHARS = 8'h04;
   localparam logic [7:0] TO_BITS  = 8'h0C;
endpackage

// ---- src/uifc_top.sv ----
// uart interrupt enable/status/priority and fifo setup logic with receive fifo
// How it works
// - receive ready on holding data or trigger
// - transmit ready on empty; enabling when empty
// - line status interrupt from status bits 1-4,7
// - fifo error flag tracks errored characters held
// - enable bits 7:4 need enhanced mode
// - interrupt on flow pin low-to-high edges
// - report highest source, hold until serviced
// - six-bit status codes by priority
// - status bit 0 low while pending
// - timeout after four chars plus twelve bits
// - transmit ready from trigger, empty, rs485
// - modem interrupt, cleared by modem status read
// - gpio toggle interrupt, cleared by state read
// - line status clears when errors read out
// - transmit ready cleared by status read or holding write
// - flow pin interrupts cleared by modem read
// - xoff/special flag, enhanced and enabled only
// - status bit 5 flags flow pin change
// - status bits 7:6 show fifo enable
// - setup bit 0 must accompany other bits
// - per-direction fifo resets, self-clearing
// - dma mode changes ready pin behaviour
// - trigger field decode tables, default one
`timescale 1ns/100ps

module uifc_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 32
) (
   input  wire logic                       clk,
   input  wire logic                       rst,
   input  wire logic                       clr,
   input  wire logic                       in_valid,
   output logic                            in_ready,
   input  wire logic [WIDTH-1:0]           in_data,
   output logic                            out_valid,
   input  wire logic                       out_ready,
   output logic [WIDTH-1:0]                out_data,
   output logic [$clog2(DEPTH):0]          count
);
   localparam int AW = $clog2(DEPTH);
   typedef struct packed {
      logic [AW-1:0] wp;
      logic [AW-1:0] rp;
      logic [AW:0]   cnt;
   } uifc_fifo_s;
   uifc_fifo_s s_q, s_d;
   logic [WIDTH-1:0] mem [DEPTH];
   logic push, pop;

   // full and empty come from the stored count, so both handshakes are clean
   assign in_ready  = (s_q.cnt != (AW+1)'(DEPTH));
   assign out_valid = (s_q.cnt != '0);
   assign out_data  = mem[s_q.rp];
   assign count     = s_q.cnt;
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;

   always_comb begin
      s_d = s_q;
      if (clr) begin
         s_d = '0;
      end else begin
         if (push) s_d.wp = s_q.wp + 1'b1;
         if (pop) s_d.rp = s_q.rp + 1'b1;
         s_d.cnt = s_q.cnt + (AW+1)'(push) - (AW+1)'(pop);
      end
   end

   always_ff @(posedge clk) begin
      if (rst) s_q <= '0;
      else s_q <= s_d;
      if (push & ~clr) mem[s_q.wp] <= in_data;
   end
endmodule

module uifc_top
   import uifc_pkg::*;
(
   input  wire logic              clk,
   input  wire logic              rst,
   input  wire logic [2:0]        reg_addr,
   input  wire logic              reg_wr,
   input  wire logic              reg_rd,
   input  wire logic [7:0]        reg_wdata,
   output logic [7:0]             reg_rdata,
   input  wire logic              enh_en,
   input  wire logic              rx_valid,
   input  wire logic [RXW-1:0]    rx_word,
   output logic                   rx_ready,
   input  wire logic              rx_overrun,
   input  wire logic              bit_tick,
   input  wire logic [3:0]        char_bits,
   input  wire logic              thr_write,
   input  wire logic [6:0]        tx_spaces,
   input  wire logic              tx_fifo_empty,
   input  wire logic              tsr_empty,
   input  wire logic              rs485_auto,
   output logic                   tx_fifo_clr,
   input  wire logic [3:0]        modem_delta,
   input  wire logic              modem_read,
   input  wire logic              rts_n,
   input  wire logic              cts_n,
   input  wire logic              auto_rts,
   input  wire logic              auto_cts,
   input  wire logic [7:0]        gpio_in,
   input  wire logic [7:0]        gpio_int_mask,
   input  wire logic              io_state_read,
   input  wire logic              xoff_match,
   input  wire logic              special_match,
   input  wire logic              xon_match,
   output logic                   irq,
   output logic                   receive_ready_pin_n,
   output logic                   transmit_ready_pin_n
);
   typedef struct packed {
      logic [7:0]       interrupt_enable_mask;
      logic             fifo_en;
      logic             dma;
      logic [1:0]       txtrg;
      logic             txtrg_set;
      logic [1:0]       rxtrg;
      logic             rxtrg_set;
      logic             ovr;
      logic [CNT_W-1:0] errcnt;
      logic             txflag;
      logic             txcond_prev;
      logic             txfill;
      logic             toflag;
      logic [7:0]       tocnt;
      logic             msflag;
      logic             gpflag;
      logic [7:0]       gpio_prev;
      logic             xoflag;
      logic             spflag;
      logic             rts_prev;
      logic             cts_prev;
      logic             fcflag;
      logic [3:0]       cur;
      logic             irq;
      logic [7:0]       rdata;
      logic             rx_ready;
      logic             rx_pin_n;
      logic             tx_pin_n;
      logic             tx_clr;
   } uifc_state_s;
   uifc_state_s s_q, s_d;

   logic             wr_ie, wr_fc, rd_rh, rd_is, rd_ls;
   logic             rx_push, rx_pop, rx_clr, f_valid;
   logic [RXW-1:0]   f_data;
   logic [CNT_W-1:0] f_cnt, cnt_after;
   logic [2:0]       head_err;
   logic [6:0]       rx_lvl, tx_lvl;
   logic             rx_cond, tx_cond, tx_set, fifo_en_d;
   logic [7:0]       pend, line_status, to_limit;
   logic [3:0]       pick;

   // status code for a source index
   function automatic logic [5:0] src_code(input logic [3:0] idx);
      case (idx)
         4'h0: src_code = ISC_LSTAT;
         4'h1: src_code = ISC_RXTO;
         4'h2: src_code = ISC_RECEIVE_READY_PIN_N;
         4'h3: src_code = ISC_TRANSMIT_READY_PIN_N;
         4'h4: src_code = ISC_MODEM;
         4'h5: src_code = ISC_GPIO;
         4'h6: src_code = ISC_XOFF;
         4'h7: src_code = ISC_FLOW;
         default: src_code = ISC_NONE;
      endcase
   endfunction

   // register port decode
   assign wr_ie = reg_wr & (reg_addr == ADDR_IEMASK);
   assign wr_fc = reg_wr & (reg_addr == ADDR_ISTAT);
   assign rd_rh = reg_rd & (reg_addr == ADDR_RHOLD);
   assign rd_is = reg_rd & (reg_addr == ADDR_ISTAT);
   assign rd_ls = reg_rd & (reg_addr == ADDR_LSTAT);

   // receive path; a disable/enable change also flushes, like a reset bit
   assign rx_push   = rx_valid & s_q.rx_ready;
   assign rx_pop    = rd_rh & f_valid;
   assign rx_clr    = wr_fc & ((reg_wdata[FC_EN] & reg_wdata[FC_RXRST])
                      | (reg_wdata[FC_EN] != s_q.fifo_en));
   assign fifo_en_d = wr_fc ? reg_wdata[FC_EN] : s_q.fifo_en;
   assign cnt_after = rx_clr ? '0 : f_cnt + CNT_W'(rx_push) - CNT_W'(rx_pop);
   assign head_err  = f_valid ? f_data[ERR_LSB +: 3] : 3'h0;

   uifc_fifo #(.WIDTH(RXW), .DEPTH(RX_DEPTH)) u_rx_fifo (
      .clk       (clk),
      .rst       (rst),
      .clr       (rx_clr),
      .in_valid  (rx_push),
      .in_ready  (),
      .in_data   (rx_word),
      .out_valid (f_valid),
      .out_ready (rd_rh),
      .out_data  (f_data),
      .count     (f_cnt)
   );

   // trigger levels; without a written field the level is one
   assign rx_lvl = (s_q.fifo_en & s_q.rxtrg_set) ? RX_LVL[s_q.rxtrg] : LVL_DEFAULT;
   assign tx_lvl = s_q.txtrg_set ? TX_LVL[s_q.txtrg] : LVL_DEFAULT;
   assign rx_cond = ({1'b0, f_cnt} >= rx_lvl);
   assign to_limit = 8'({char_bits, 2'b00}) * (TO_CHARS >> 2) + TO_BITS;

   // transmit ready condition
   always_comb begin
      if (rs485_auto)
         tx_cond = tsr_empty & tx_fifo_empty;
      else if (~s_q.fifo_en | ~s_q.txtrg_set)
         tx_cond = tx_fifo_empty;
      else
         tx_cond = (tx_spaces > tx_lvl) | (tx_fifo_empty & ~s_q.txfill);
   end
   assign tx_set = (tx_cond & ~s_q.txcond_prev)
                 | (wr_ie & reg_wdata[IE_TRANSMIT_READY_PIN_N] & ~s_q.interrupt_enable_mask[IE_TRANSMIT_READY_PIN_N] & tx_cond);

   // line status view
   assign line_status = {(s_q.errcnt != '0), tsr_empty & tx_fifo_empty, tx_fifo_empty,
                 head_err, s_q.ovr, f_valid};

   // pending sources, index order is priority order
   always_comb begin
      pend[0] = s_q.interrupt_enable_mask[IE_LSTAT] & (s_q.ovr | (|head_err) | (s_q.errcnt != '0));
      pend[1] = s_q.interrupt_enable_mask[IE_RECEIVE_READY_PIN_N] & s_q.toflag;
      pend[2] = s_q.interrupt_enable_mask[IE_RECEIVE_READY_PIN_N] & rx_cond;
      pend[3] = s_q.interrupt_enable_mask[IE_TRANSMIT_READY_PIN_N] & s_q.txflag;
      pend[4] = s_q.interrupt_enable_mask[IE_MODEM] & s_q.msflag;
      pend[5] = s_q.gpflag;
      pend[6] = enh_en & s_q.interrupt_enable_mask[IE_XOFF] & (s_q.xoflag | s_q.spflag);
      pend[7] = enh_en & s_q.fcflag;
   end

   // keep the reported source until it is serviced, else take the highest
   always_comb begin
      pick = SRC_NONE;
      if (s_q.cur != SRC_NONE && pend[s_q.cur[2:0]]) begin
         pick = s_q.cur;
      end else begin
         for (int i = 7; i >= 0; i--) begin
            if (pend[i]) pick = 4'(i);
         end
      end
   end

   // next state
   always_comb begin
      s_d = s_q;
      // enable mask: upper bits only in enhanced mode
      if (wr_ie) begin
         s_d.interrupt_enable_mask = enh_en ? reg_wdata : ((s_q.interrupt_enable_mask & ~IE_LOW_MASK) | (reg_wdata & IE_LOW_MASK));
      end
      // fifo setup: other bits only land together with the enable bit
      s_d.fifo_en = fifo_en_d;
      s_d.tx_clr = wr_fc & ((reg_wdata[FC_EN] & reg_wdata[FC_TXRST])
                   | (reg_wdata[FC_EN] != s_q.fifo_en));
      if (wr_fc & reg_wdata[FC_EN]) begin
         s_d.dma = reg_wdata[FC_DMA];
         s_d.rxtrg = reg_wdata[FC_RXTRG +: 2];
         s_d.rxtrg_set = 1'b1;
         if (enh_en) begin
            s_d.txtrg = reg_wdata[FC_TXTRG +: 2];
            s_d.txtrg_set = 1'b1;
         end
      end
      // errored characters held; line status clears once they are read out
      s_d.errcnt = rx_clr ? '0 : s_q.errcnt + CNT_W'(rx_push & (|rx_word[ERR_LSB +: 3]))
                   - CNT_W'(rx_pop & (|head_err));
      s_d.ovr = rx_overrun | (s_q.ovr & ~rd_ls);
      // receive timeout timer; any push or pop restarts it
      if (rx_push | rx_pop | rx_clr | (f_cnt == '0)) begin
         s_d.tocnt = '0;
      end else if (bit_tick & ~s_q.toflag) begin
         s_d.tocnt = s_q.tocnt + 8'h01;
      end
      s_d.toflag = (bit_tick & ~s_q.toflag & (f_cnt != '0) & ~rx_push & ~rx_pop & ~rx_clr
                   & (s_q.tocnt + 8'h01 >= to_limit))
                   | (s_q.toflag & ~rd_rh & ~rx_clr);
      // transmit ready; set wins over clear
      s_d.txcond_prev = tx_cond;
      if (tx_fifo_empty) s_d.txfill = 1'b0;
      else if (tx_spaces <= tx_lvl) s_d.txfill = 1'b1;
      s_d.txflag = tx_set | (s_q.txflag & ~thr_write
                   & ~(rd_is & (s_q.cur == 4'h3)));
      // modem, gpio, software flow and flow pin flags
      s_d.msflag = (|modem_delta) | (s_q.msflag & ~modem_read);
      s_d.gpio_prev = gpio_in;
      s_d.gpflag = (|((gpio_in ^ s_q.gpio_prev) & gpio_int_mask))
                   | (s_q.gpflag & ~io_state_read);
      s_d.xoflag = (enh_en & s_q.interrupt_enable_mask[IE_XOFF] & xoff_match) | (s_q.xoflag & ~xon_match);
      s_d.spflag = (enh_en & s_q.interrupt_enable_mask[IE_XOFF] & special_match)
                   | (s_q.spflag & ~(rd_is & (s_q.cur == 4'h6)));
      s_d.rts_prev = rts_n;
      s_d.cts_prev = cts_n;
      s_d.fcflag = (enh_en & ((s_q.interrupt_enable_mask[IE_RTS] & auto_rts & rts_n & ~s_q.rts_prev)
                   | (s_q.interrupt_enable_mask[IE_CTS] & auto_cts & cts_n & ~s_q.cts_prev)))
                   | (s_q.fcflag & ~modem_read);
      // status and request output
      s_d.cur = pick;
      s_d.irq = (pick != SRC_NONE);
      // register read data, held between reads; unmapped reads give zero
      if (reg_rd) begin
         case (reg_addr)
            ADDR_RHOLD:  s_d.rdata = f_valid ? f_data[7:0] : 8'h00;
            ADDR_IEMASK: s_d.rdata = s_q.interrupt_enable_mask;
            ADDR_ISTAT:  s_d.rdata = {s_q.fifo_en, s_q.fifo_en, src_code(s_q.cur)};
            ADDR_LSTAT:  s_d.rdata = line_status;
            default:     s_d.rdata = 8'h00;
         endcase
      end
      // receive accepts one character without the fifo, a full fifo with it
      s_d.rx_ready = fifo_en_d ? (cnt_after < CNT_W'(RX_DEPTH)) : (cnt_after == '0);
      // dma mode: ready pins follow trigger/space levels rather than any data
      s_d.rx_pin_n = s_q.dma ? ~(rx_cond | s_q.toflag) : ~f_valid;
      s_d.tx_pin_n = s_q.dma ? ~(tx_spaces > tx_lvl) : ~tx_fifo_empty;
   end

   // state register; pins idle high, no source reported
   always_ff @(posedge clk) begin
      if (rst) begin
         s_q <= '0;
         s_q.interrupt_enable_mask <= IEMASK_RST;
         s_q.cur <= SRC_NONE;
         s_q.rx_pin_n <= 1'b1;
         s_q.tx_pin_n <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   assign reg_rdata            = s_q.rdata;
   assign rx_ready             = s_q.rx_ready;
   assign tx_fifo_clr          = s_q.tx_clr;
   assign irq                  = s_q.irq;
   assign receive_ready_pin_n  = s_q.rx_pin_n;
   assign transmit_ready_pin_n = s_q.tx_pin_n;

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   sequence s_isr_read;
      reg_rd && reg_addr == ADDR_ISTAT;
   endsequence

   property p_irq_follows;
      (|pend) |=> irq;
   endproperty
   a_irq_follows: assert property (p_irq_follows) else $error("request not raised");

   property p_idle_code;
      s_isr_read and (s_q.cur == SRC_NONE) |=> reg_rdata[5:0] == 6'h01;
   endproperty
   a_idle_code: assert property (p_idle_code) else $error("idle code wrong");

   property p_fifo_bits;
      s_isr_read |=> reg_rdata[7:6] == {2{$past(s_q.fifo_en)}};
   endproperty
   a_fifo_bits: assert property (p_fifo_bits) else $error("fifo status bits wrong");

   property p_hold;
      (s_q.cur != SRC_NONE) && pend[s_q.cur[2:0]] |=> s_q.cur == $past(s_q.cur);
   endproperty
   a_hold: assert property (p_hold) else $error("pending source replaced");

   property p_ier_guard;
      wr_ie && !enh_en |=> s_q.interrupt_enable_mask[7:4] == $past(s_q.interrupt_enable_mask[7:4]);
   endproperty
   a_ier_guard: assert property (p_ier_guard) else $error("upper enables written");

   property p_fcr_ignore;
      wr_fc && !reg_wdata[0] |=> s_q.dma == $past(s_q.dma) && !s_q.fifo_en;
   endproperty
   a_fcr_ignore: assert property (p_fcr_ignore) else $error("setup bits taken");

   property p_tx_on_enable;
      wr_ie && reg_wdata[1] && !s_q.interrupt_enable_mask[1] && tx_cond |=> s_q.txflag ##1 irq || s_q.cur < 4'h3;
   endproperty
   a_tx_on_enable: assert property (p_tx_on_enable) else $error("no transmit ready");

   property p_thr_clear;
      thr_write && !tx_set |=> !s_q.txflag;
   endproperty
   a_thr_clear: assert property (p_thr_clear) else $error("transmit ready kept");

   property p_txtrg_guard;
      wr_fc && !enh_en |=> s_q.txtrg == $past(s_q.txtrg);
   endproperty
   a_txtrg_guard: assert property (p_txtrg_guard) else $error("trigger written");

   property p_rx_reset;
      rx_clr |=> f_cnt == '0 && s_q.errcnt == '0;
   endproperty
   a_rx_reset: assert property (p_rx_reset) else $error("receive fifo not reset");
endmodule

// ---- sim/uifc_host.sv ----
// host model for the block's byte-wide register port
`timescale 1ns/100ps
module uifc_host (
   input  wire logic       clk,
   output logic [2:0]      reg_addr,
   output logic            reg_wr,
   output logic            reg_rd,
   output logic [7:0]      reg_wdata,
   input  wire logic [7:0] reg_rdata
);
   // idle port at time zero
   initial begin
      reg_addr  = 3'h0;
      reg_wr    = 1'b0;
      reg_rd    = 1'b0;
      reg_wdata = 8'h00;
   end
   // one write; data inverted on release so a stale byte is never mistaken for a live one
   task automatic wr(input logic [2:0] a, input logic [7:0] v);
      @(posedge clk);
      reg_addr  <= a;
      reg_wdata <= v;
      reg_wr    <= 1'b1;
      @(posedge clk);
      reg_wr    <= 1'b0;
      reg_wdata <= ~v;
   endtask
   // read data lands one edge after the strobe edge and stands until the next read
   task automatic rd(input logic [2:0] a, output logic [7:0] v);
      @(posedge clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge clk);
      reg_rd   <= 1'b0;
      @(posedge clk);
      v = reg_rdata;
   endtask
endmodule

// ---- sim/uart_interrupt_and_fifo_control_tb.sv ----
// self-checking bench for the uart interrupt and fifo control block
`timescale 1ns/100ps
module uart_interrupt_and_fifo_control_tb
   import uifc_pkg::*;
;
   logic           clk, rst, reg_wr, reg_rd, enh_en, rx_valid, rx_ready, rx_overrun, bit_tick;
   logic           thr_write, tx_fifo_empty, tx_fifo_clr, modem_read, cts_n, auto_cts, rts_n, auto_rts, irq;
   logic           io_state_read, xoff_match, xon_match, special_match, rxp_n, txp_n;
   logic [2:0]     reg_addr;
   logic [3:0]     char_bits, modem_delta;
   logic [6:0]     tx_spaces;
   logic [7:0]     reg_wdata, reg_rdata, gpio_in, gpio_int_mask, d, ie;
   logic [RXW-1:0] rx_w, q[$];
   bit             fifo_en, tx_f, mdm_f, gp_f, xo_f, fl_f, to_f, ov_f;
   int             trig, cnt, n_mismatch, comparisons;

   assign tx_spaces = tx_fifo_empty ? 7'h40 : 7'h3F;

   uifc_host host_u (.clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));

   uifc_top dut_u (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .enh_en(enh_en), .rx_valid(rx_valid),
      .rx_word(rx_w), .rx_ready(rx_ready), .rx_overrun(rx_overrun),
      .bit_tick(bit_tick), .char_bits(char_bits), .thr_write(thr_write), .tx_spaces(tx_spaces),
      .tx_fifo_empty(tx_fifo_empty), .tsr_empty(1'b1), .rs485_auto(1'b0), .tx_fifo_clr(tx_fifo_clr),
      .modem_delta(modem_delta), .modem_read(modem_read), .rts_n(rts_n), .cts_n(cts_n),
      .auto_rts(auto_rts), .auto_cts(auto_cts), .gpio_in(gpio_in), .gpio_int_mask(gpio_int_mask),
      .io_state_read(io_state_read), .xoff_match(xoff_match), .special_match(special_match),
      .xon_match(xon_match), .irq(irq), .receive_ready_pin_n(rxp_n), .transmit_ready_pin_n(txp_n));

   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask

   task automatic chk(input string nm, input logic [7:0] s, input logic [7:0] e);
      comparisons++;
      if (s !== e) begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
      end
   endtask

   // reference status: highest pending source wins, fifo enable in the top bits
   function automatic logic [7:0] stat();
      logic [5:0] c;
      bit         err;
      err = ov_f;
      foreach (q[i]) if (q[i][10:8] != 3'h0) err = 1;
      if (ie[IE_LSTAT] && err) c = ISC_LSTAT;
      else if (to_f) c = ISC_RXTO;
      else if (ie[IE_RECEIVE_READY_PIN_N] && q.size() >= trig) c = ISC_RECEIVE_READY_PIN_N;
      else if (tx_f) c = ISC_TRANSMIT_READY_PIN_N;
      else if (mdm_f) c = ISC_MODEM;
      else if (gp_f) c = ISC_GPIO;
      else if (xo_f) c = ISC_XOFF;
      else if (fl_f) c = ISC_FLOW;
      else c = ISC_NONE;
      return {fifo_en, fifo_en, c};
   endfunction

   // settle, then compare request line and status; reporting transmit ready clears it
   task automatic st();
      logic [7:0] e, v;
      cyc(4);
      e = stat();
      chk("irq", {7'h00, irq}, {7'h00, e[5:0] != ISC_NONE});
      host_u.rd(ADDR_ISTAT, v);
      chk("status", v, e);
      if (e[5:0] == ISC_TRANSMIT_READY_PIN_N) tx_f = 0;
   endtask

   // offer one word and hold it until the block takes it
   task automatic push(input logic [RXW-1:0] v);
      int k = 0;
      @(posedge clk);
      rx_valid <= 1'b1;
      rx_w     <= v;
      do begin
         @(posedge clk);
         k++;
      end while (rx_ready !== 1'b1 && k < 40);
      rx_valid <= 1'b0;
      rx_w     <= ~v;
      q.push_back(v);
      chk("rx taken", {7'h00, rx_ready}, 8'h01);
   endtask

   task automatic pop();
      logic [7:0]     v;
      logic [RXW-1:0] h;
      host_u.rd(ADDR_RHOLD, v);
      h = q.pop_front();
      to_f = 0;
      chk("rx data", v, h[7:0]);
   endtask

   task automatic results();
      $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask

   // watchdog: the sequence needs only a few hundred cycles
   initial begin
      repeat (20000) @(posedge clk);
      n_mismatch++;
      results();
   end

   // main sequence
   initial begin
      rst = 1'b1;
      {enh_en, rx_valid, rx_overrun, bit_tick, thr_write, tx_fifo_empty, modem_read} = '0;
      {cts_n, auto_cts, rts_n, auto_rts, special_match, io_state_read, xoff_match, xon_match} = '0;
      {ie, fifo_en, tx_f, mdm_f, gp_f, xo_f, fl_f, to_f, ov_f} = '0;
      rx_w = '0;
      char_bits = 4'h8;
      modem_delta = 4'h0;
      gpio_in = 8'h00;
      gpio_int_mask = 8'hFF;
      trig = 1;
      n_mismatch = 0;
      comparisons = 0;
      void'($urandom(47));
      cyc(16);
      rst <= 1'b0;
      st();
      host_u.rd(ADDR_IEMASK, d);
      chk("enable mask", d, IEMASK_RST);
      chk("rx pin", {7'h00, rxp_n}, 8'h01);
      // upper enables only take in enhanced mode
      host_u.wr(ADDR_IEMASK, 8'hF0);
      host_u.rd(ADDR_IEMASK, d);
      chk("enable mask", d, 8'h00);
      enh_en <= 1'b1;
      host_u.wr(ADDR_IEMASK, 8'hA0);
      ie = 8'hA0;
      host_u.rd(ADDR_IEMASK, d);
      chk("enable mask", d, ie);
      // xoff match flags, xon clears
      @(posedge clk) xoff_match <= 1'b1;
      @(posedge clk) xoff_match <= 1'b0;
      xo_f = 1;
      st();
      @(posedge clk) xon_match <= 1'b1;
      @(posedge clk) xon_match <= 1'b0;
      xo_f = 0;
      st();
      // special character flags the same source; only a status read clears it
      @(posedge clk) special_match <= 1'b1;
      @(posedge clk) special_match <= 1'b0;
      xo_f = 1;
      st();
      xo_f = 0;
      st();
      // clear-to-send rising under automatic flow control, cleared by a modem read
      auto_cts <= 1'b1;
      @(posedge clk) cts_n <= 1'b1;
      fl_f = 1;
      st();
      @(posedge clk) modem_read <= 1'b1;
      @(posedge clk) modem_read <= 1'b0;
      fl_f = 0;
      st();
      // request-to-send rising, its enable set only for this check
      host_u.wr(ADDR_IEMASK, 8'hE0);
      auto_rts <= 1'b1;
      @(posedge clk) rts_n <= 1'b1;
      fl_f = 1;
      st();
      @(posedge clk) modem_read <= 1'b1;
      @(posedge clk) modem_read <= 1'b0;
      fl_f = 0;
      host_u.wr(ADDR_IEMASK, 8'hA0);
      st();
      // low enables still writable, upper ones kept
      enh_en <= 1'b0;
      host_u.wr(ADDR_IEMASK, 8'h0D);
      ie = 8'hAD;
      host_u.rd(ADDR_IEMASK, d);
      chk("enable mask", d, ie);
      for (int i = 0; i < 4; i++) begin
         @(posedge clk) modem_delta <= 4'h1 << i;
         @(posedge clk) modem_delta <= 4'h0;
         mdm_f = 1;
         st();
         @(posedge clk) modem_read <= 1'b1;
         @(posedge clk) modem_read <= 1'b0;
         mdm_f = 0;
         st();
      end
      @(posedge clk) gpio_in <= gpio_in ^ 8'($urandom_range(255, 1));
      gp_f = 1;
      st();
      @(posedge clk) io_state_read <= 1'b1;
      @(posedge clk) io_state_read <= 1'b0;
      gp_f = 0;
      st();
      // holding-register mode: clean char, then errored char, line status ahead of receive ready
      push({3'b000, 8'($urandom)});
      st();
      chk("rx pin", {7'h00, rxp_n}, 8'h00);
      pop();
      st();
      push({3'b001, 8'($urandom)});
      st();
      host_u.rd(ADDR_LSTAT, d);
      chk("line status", d & 8'h9D, 8'h85);
      pop();
      st();
      @(posedge clk) rx_overrun <= 1'b1;
      @(posedge clk) rx_overrun <= 1'b0;
      ov_f = 1;
      st();
      host_u.rd(ADDR_LSTAT, d);
      ov_f = 0;
      st();
      // transmit ready: at once on enable, cleared by status read, then by a holding write
      tx_fifo_empty <= 1'b1;
      host_u.wr(ADDR_IEMASK, 8'h0F);
      ie = 8'hAF;
      tx_f = 1;
      chk("tx pin", {7'h00, txp_n}, 8'h00);
      st();
      st();
      @(posedge clk) tx_fifo_empty <= 1'b0;
      @(posedge clk) tx_fifo_empty <= 1'b1;
      cyc(4);
      chk("irq", {7'h00, irq}, 8'h01);
      @(posedge clk) thr_write <= 1'b1;
      tx_fifo_empty <= 1'b0;
      @(posedge clk) thr_write <= 1'b0;
      st();
      host_u.wr(ADDR_IEMASK, 8'h0D);
      ie = 8'hAD;
      // fifo mode: trigger code 00 means eight characters
      host_u.wr(ADDR_ISTAT, 8'h01);
      fifo_en = 1;
      trig = RX_LVL[0];
      st();
      for (int i = 0; i < 8; i++) begin
         push({3'b000, 8'($urandom)});
         if (i >= 6) st();
      end
      pop();
      st();
      // dma mode: receive pin waits for the trigger, transmit pin follows free spaces
      chk("rx pin", {7'h00, rxp_n}, 8'h00);
      chk("tx pin", {7'h00, txp_n}, 8'h01);
      host_u.wr(ADDR_ISTAT, 8'h09);
      cyc(2);
      chk("rx pin", {7'h00, rxp_n}, 8'h01);
      chk("tx pin", {7'h00, txp_n}, 8'h00);
      // receive reset drops the old characters; the timeout char read back proves it
      host_u.wr(ADDR_ISTAT, 8'h03);
      q.delete();
      char_bits <= 4'h5;
      push({3'b000, 8'($urandom)});
      bit_tick <= 1'b1;
      cyc(16);
      st();
      cyc(20);
      to_f = 1;
      st();
      pop();
      bit_tick <= 1'b0;
      st();
      // transmit reset is a single pulse
      host_u.wr(ADDR_ISTAT, 8'h05);
      cnt = 0;
      repeat (6) @(posedge clk) if (tx_fifo_clr === 1'b1) cnt++;
      chk("tx clear pulses", 8'(cnt), 8'h01);
      // bit 0 low disables the fifos and drops the other bits
      host_u.wr(ADDR_ISTAT, 8'h06);
      fifo_en = 0;
      trig = 1;
      st();
      results();
   end
endmodule
